// file: design/reset_and_stop_recovery_ctrl.sv
// Purpose: Reset source gathering, reset pin indicator, stop mode recovery
// Assumes: Inputs synchronous to ref_clk except rst_pin_i, debug_pin_n, gpio
// Notes: Overview of operation below
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module reset_and_stop_recovery_ctrl #(
	parameter int LAT_LONG = reset_ctrl_pkg::LAT_LONG_CYC,
	parameter int WAKE_W = 8,
	parameter int STOP_PIN_MIN = 4,
	parameter int WAKE_MIN = 4
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [reset_ctrl_pkg::ADDR_W-1:0] addr,
	input wire logic [reset_ctrl_pkg::DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [reset_ctrl_pkg::DATA_W-1:0] rdata,
	input wire reset_ctrl_pkg::option_bits_type options,
	input wire logic watchdog_timeout,
	input wire logic stop_enter,
	input wire logic irq_global_en,
	input wire logic power_event,
	input wire logic [WAKE_W-1:0] gpio_in,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe,
	input wire logic port_drive_en,
	input wire logic debug_pin_n,
	input wire logic supply_low,
	input wire logic brownout_disable,
	output logic cpu_rst,
	output logic ctl_reg_rst,
	output logic stop_reinit,
	output logic ipo_force,
	output logic pc_load,
	output logic [15:0] reset_vector,
	output logic port_input_en,
	output logic in_stop,
	output logic wdt_irq,
	output logic low_supply_irq
);
	import reset_ctrl_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Synchronisers; first stages feed only second stages
	logic pin_s1_ff, pin_s2_ff, dbg_s1_ff, dbg_s2_ff;
	logic [WAKE_W-1:0] gpio_s1_ff, gpio_s2_ff;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
			dbg_s1_ff <= 1'b1;
			dbg_s2_ff <= 1'b1;
			gpio_s1_ff <= '0;
			gpio_s2_ff <= '0;
		end else if (ce) begin
			pin_s1_ff <= rst_pin_i;
			pin_s2_ff <= pin_s1_ff;
			dbg_s1_ff <= debug_pin_n;
			dbg_s2_ff <= dbg_s1_ff;
			gpio_s1_ff <= gpio_in;
			gpio_s2_ff <= gpio_s1_ff;
		end
	end

	state_type st_ff, nxt_st;
	cause_type cause_ff, nxt_cause;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [FILT_W-1:0] pin_cnt_ff, nxt_pin_cnt, wake_cnt_ff, nxt_wake_cnt;
	logic [WAKE_W-1:0] wake_snap_ff, nxt_wake_snap, wake_en_ff, nxt_wake_en;
	logic [1:0] blank_ff, nxt_blank;
	logic dbg_req_ff, nxt_dbg_req, lsd_en_ff, nxt_lsd_en;
	logic by_wdt_ff, nxt_by_wdt, irq_pend_ff, nxt_irq_pend;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic oe_ff, nxt_oe, cpu_rst_ff, nxt_cpu_rst, ctl_rst_ff, nxt_ctl_rst;
	logic reinit_ff, nxt_reinit, ipo_ff, nxt_ipo, pc_ff, nxt_pc;
	logic pie_ff, nxt_pie, stop_ff, nxt_stop, wirq_ff, nxt_wirq;
	logic lirq_ff, nxt_lirq;

	logic lsd_live, blank, pin_low, pin_qual, wake_diff, wake_fire;
	logic cnt_done, sys_rst, ext_rst;
	logic [FILT_W-1:0] pin_thr;
	logic [CNT_W-1:0] target;
	cause_type rst_row;

	// Detector shares circuitry with brown-out, so disable covers both
	assign lsd_live = supply_low & ~brownout_disable;
	// Own drive reads back low through the synchroniser; mask it
	assign blank = oe_ff | (|blank_ff);
	assign pin_low = ~pin_s2_ff & ~blank;
	// Stop mode uses the wider glitch filter
	assign pin_thr = (st_ff == ST_STOP) ? FILT_W'(STOP_PIN_MIN) :
		FILT_W'(PIN_QUAL_CYC);
	// Third consecutive synced low (fourth in stop): four-cycle pulse caught unless rst_pin_oe is set or was set in the last two cycles
	assign pin_qual = pin_low && (pin_cnt_ff >= pin_thr - FILT_W'(1));
	assign wake_diff = |((gpio_s2_ff ^ wake_snap_ff) & wake_en_ff);
	assign wake_fire = wake_diff &&
		(wake_cnt_ff >= FILT_W'(WAKE_MIN) - FILT_W'(1));
	assign target = CNT_W'(STARTUP_CYC) + (options.xtal_enable_option ?
		CNT_W'(LAT_LONG) : CNT_W'(LAT_SHORT_CYC));
	assign cnt_done = (cnt_ff == target - CNT_W'(1));

	always_comb begin
		sys_rst = 1'b0;
		ext_rst = 1'b0;
		rst_row = CAUSE_POR;
		if (power_event) begin
			sys_rst = 1'b1;
		end else if (st_ff == ST_RUN && dbg_req_ff) begin
			sys_rst = 1'b1;
		end else if (st_ff == ST_STOP && !dbg_s2_ff) begin
			sys_rst = 1'b1;
		end else if ((st_ff == ST_RUN || st_ff == ST_STOP) && pin_qual) begin
			sys_rst = 1'b1;
			ext_rst = 1'b1;
			rst_row = CAUSE_EXT;
		end else if (st_ff == ST_RUN && watchdog_timeout &&
			options.watchdog_reset_select_option) begin
			sys_rst = 1'b1;
			rst_row = CAUSE_WDT;
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_cause = cause_ff;
		nxt_cnt = cnt_ff;
		nxt_pin_cnt = pin_low ? ((pin_cnt_ff == '1) ? pin_cnt_ff :
			pin_cnt_ff + FILT_W'(1)) : '0;
		nxt_wake_cnt = '0;
		nxt_wake_snap = wake_snap_ff;
		nxt_wake_en = wake_en_ff;
		nxt_blank = {blank_ff[0], oe_ff};
		nxt_dbg_req = dbg_req_ff;
		nxt_lsd_en = lsd_en_ff;
		nxt_by_wdt = by_wdt_ff;
		nxt_irq_pend = irq_pend_ff;
		nxt_rdata = '0;
		nxt_ipo = 1'b0;
		nxt_pc = 1'b0;
		nxt_wirq = 1'b0;
		if (rd_stb) begin
			if (hit(addr, REG_RESET_CAUSE)) begin
				nxt_rdata = {cause_ff, 3'h0, lsd_live};
				nxt_cause = '0;
			end else if (hit(addr, REG_DEBUG_CTRL)) begin
				nxt_rdata[DBG_RST_BIT] = dbg_req_ff;
			end else if (hit(addr, REG_WAKE_EN)) begin
				nxt_rdata = DATA_W'(wake_en_ff);
			end else if (hit(addr, REG_LOW_SUPPLY_CTRL)) begin
				nxt_rdata[LSD_IRQ_EN_BIT] = lsd_en_ff;
			end
		end
		if (wr_stb) begin
			if (hit(addr, REG_DEBUG_CTRL)) begin
				nxt_dbg_req = wdata[DBG_RST_BIT];
			end else if (hit(addr, REG_WAKE_EN)) begin
				nxt_wake_en = WAKE_W'(wdata);
			end else if (hit(addr, REG_LOW_SUPPLY_CTRL)) begin
				nxt_lsd_en = wdata[LSD_IRQ_EN_BIT];
			end
		end
		if (sys_rst) begin
			nxt_st = ST_HOLD;
			nxt_cnt = '0;
			// Event row written after read clear: set wins
			nxt_cause = rst_row;
			nxt_wake_en = '0;
			nxt_lsd_en = 1'b0;
			nxt_irq_pend = 1'b0;
		end else begin
			case (st_ff)
			ST_RUN: begin
				if (watchdog_timeout &&
					!options.watchdog_reset_select_option) begin
					nxt_wirq = 1'b1;
				end else if (stop_enter) begin
					nxt_st = ST_STOP;
					nxt_wake_snap = gpio_s2_ff;
				end
			end
			ST_HOLD: begin
				nxt_dbg_req = 1'b0;
				nxt_cnt = cnt_ff + CNT_W'(1);
				if (cnt_done) begin
					nxt_st = ST_PIN_WAIT;
				end
			end
			ST_PIN_WAIT: begin
				// Held until the pin is released
				if (pin_s2_ff) begin
					nxt_st = ST_RUN;
					nxt_pc = 1'b1;
					nxt_ipo = 1'b1;
				end
			end
			ST_STOP: begin
				nxt_wake_cnt = wake_diff ? ((wake_cnt_ff == '1) ?
					wake_cnt_ff : wake_cnt_ff + FILT_W'(1)) : '0;
				if (watchdog_timeout) begin
					nxt_st = ST_RECOVER;
					nxt_cnt = '0;
					nxt_by_wdt = 1'b1;
					nxt_irq_pend = ~options.watchdog_reset_select_option;
				end else if (wake_fire) begin
					nxt_st = ST_RECOVER;
					nxt_cnt = '0;
					nxt_by_wdt = 1'b0;
				end
			end
			ST_RECOVER: begin
				nxt_cnt = cnt_ff + CNT_W'(1);
				if (cnt_done) begin
					nxt_st = ST_RUN;
					nxt_pc = 1'b1;
					nxt_ipo = 1'b1;
					nxt_cause = by_wdt_ff ? CAUSE_SMR_WDT :
						CAUSE_SMR_PIN;
					nxt_wirq = irq_pend_ff & irq_global_en;
					nxt_irq_pend = 1'b0;
				end
			end
			default: begin
				nxt_st = ST_HOLD;
				nxt_cnt = '0;
			end
			endcase
		end
		nxt_oe = (nxt_st == ST_HOLD) | port_drive_en;
		nxt_cpu_rst = (nxt_st == ST_HOLD) || (nxt_st == ST_PIN_WAIT) ||
			(nxt_st == ST_RECOVER);
		nxt_ctl_rst = (nxt_st == ST_HOLD) || (nxt_st == ST_PIN_WAIT);
		nxt_reinit = (nxt_st == ST_RECOVER);
		nxt_pie = (nxt_st == ST_RUN);
		nxt_stop = (nxt_st == ST_STOP);
		nxt_lirq = lsd_live & lsd_en_ff;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= ST_HOLD;
			cause_ff <= CAUSE_POR;
			cnt_ff <= '0;
			pin_cnt_ff <= '0;
			wake_cnt_ff <= '0;
			wake_snap_ff <= '0;
			wake_en_ff <= '0;
			blank_ff <= 2'h3;
			dbg_req_ff <= 1'b0;
			lsd_en_ff <= 1'b0;
			by_wdt_ff <= 1'b0;
			irq_pend_ff <= 1'b0;
			rdata_ff <= '0;
			oe_ff <= 1'b1;
			cpu_rst_ff <= 1'b1;
			ctl_rst_ff <= 1'b1;
			reinit_ff <= 1'b0;
			ipo_ff <= 1'b0;
			pc_ff <= 1'b0;
			pie_ff <= 1'b0;
			stop_ff <= 1'b0;
			wirq_ff <= 1'b0;
			lirq_ff <= 1'b0;
		end else if (ce) begin
			st_ff <= nxt_st;
			cause_ff <= nxt_cause;
			cnt_ff <= nxt_cnt;
			pin_cnt_ff <= nxt_pin_cnt;
			wake_cnt_ff <= nxt_wake_cnt;
			wake_snap_ff <= nxt_wake_snap;
			wake_en_ff <= nxt_wake_en;
			blank_ff <= nxt_blank;
			dbg_req_ff <= nxt_dbg_req;
			lsd_en_ff <= nxt_lsd_en;
			by_wdt_ff <= nxt_by_wdt;
			irq_pend_ff <= nxt_irq_pend;
			rdata_ff <= nxt_rdata;
			oe_ff <= nxt_oe;
			cpu_rst_ff <= nxt_cpu_rst;
			ctl_rst_ff <= nxt_ctl_rst;
			reinit_ff <= nxt_reinit;
			ipo_ff <= nxt_ipo;
			pc_ff <= nxt_pc;
			pie_ff <= nxt_pie;
			stop_ff <= nxt_stop;
			wirq_ff <= nxt_wirq;
			lirq_ff <= nxt_lirq;
		end
	end

	logic rst_out_ff;
	logic [15:0] vec_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rst_out_ff <= 1'b0;
			vec_ff <= RESET_VECTOR_ADDR;
		end else if (ce) begin
			rst_out_ff <= 1'b0;
			vec_ff <= RESET_VECTOR_ADDR;
		end
	end

	assign rdata = rdata_ff;
	assign rst_pin_o = rst_out_ff;
	assign rst_pin_oe = oe_ff;
	assign cpu_rst = cpu_rst_ff;
	assign ctl_reg_rst = ctl_rst_ff;
	assign stop_reinit = reinit_ff;
	assign ipo_force = ipo_ff;
	assign pc_load = pc_ff;
	assign reset_vector = vec_ff;
	assign port_input_en = pie_ff;
	assign in_stop = stop_ff;
	assign wdt_irq = wirq_ff;
	assign low_supply_irq = lirq_ff;

	// Checks: length of reset hold, measured independently
	logic [CNT_W-1:0] chk_len_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			chk_len_ff <= '0;
		end else if (ce) begin
			if (st_ff != nxt_st || power_event) begin
				chk_len_ff <= '0;
			end else begin
				chk_len_ff <= chk_len_ff + CNT_W'(1);
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn || !ce);

	property p_wdt_reset;
		st_ff == ST_RUN && watchdog_timeout &&
			options.watchdog_reset_select_option && !power_event
			|=> st_ff == ST_HOLD ##1 cpu_rst && rst_pin_oe;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset)
		else $error("watchdog reset not taken");

	property p_wdt_flag;
		st_ff == ST_RUN && sys_rst && rst_row == CAUSE_WDT
			|=> cause_ff.watchdog_cause_flag && !cause_ff.por;
	endproperty
	a_wdt_flag: assert property (p_wdt_flag)
		else $error("watchdog cause flag missing");

	property p_pin_wait;
		st_ff == ST_PIN_WAIT && !pin_s2_ff |=> cpu_rst;
	endproperty
	a_pin_wait: assert property (p_pin_wait)
		else $error("left reset while pin low");

	property p_ext_flag;
		ext_rst && !power_event |=> cause_ff == CAUSE_EXT;
	endproperty
	a_ext_flag: assert property (p_ext_flag)
		else $error("external cause flag missing");

	property p_indicator;
		$rose(st_ff == ST_HOLD) |-> ##1 rst_pin_oe [*2];
	endproperty
	a_indicator: assert property (p_indicator)
		else $error("reset pin not driven during hold");

	property p_latency;
		st_ff == ST_HOLD && nxt_st == ST_PIN_WAIT
			|-> chk_len_ff == target - CNT_W'(1);
	endproperty
	a_latency: assert property (p_latency)
		else $error("reset latency wrong");

	property p_dbg_clear;
		st_ff == ST_HOLD |=> !dbg_req_ff;
	endproperty
	a_dbg_clear: assert property (p_dbg_clear)
		else $error("debug reset request not cleared");

	property p_smr_flag;
		st_ff == ST_RECOVER && cnt_done && !sys_rst
			|=> cause_ff.stop_recovery && pc_load
			&& ipo_force && !cpu_rst;
	endproperty
	a_smr_flag: assert property (p_smr_flag)
		else $error("stop recovery completion wrong");

	property p_read_clear;
		rd_stb && hit(addr, REG_RESET_CAUSE) && !sys_rst &&
			!(st_ff == ST_RECOVER && cnt_done) |=> cause_ff == '0;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("cause flags not cleared by read");

	property p_lsd_live;
		rd_stb && hit(addr, REG_RESET_CAUSE)
			|=> rdata[LSD_BIT] == $past(lsd_live);
	endproperty
	a_lsd_live: assert property (p_lsd_live)
		else $error("low supply flag wrong");

	property p_stop_port;
		st_ff == ST_STOP || st_ff == ST_RECOVER |-> !port_input_en;
	endproperty
	a_stop_port: assert property (p_stop_port)
		else $error("port capture enabled in stop");

	c_wdt_reset: cover property (p_wdt_reset);
	c_smr: cover property (st_ff == ST_STOP ##1 st_ff == ST_RECOVER);
	c_pin_wait: cover property (st_ff == ST_PIN_WAIT ##1 st_ff == ST_RUN);
endmodule
`default_nettype wire

// file: design/reset_ctrl_pkg.sv
// Purpose: Shared constants and types of the reset and stop recovery block
// Assumes: ref_clk at 125 MHz doubles as the internal oscillator count base
// Notes: Offsets are byte addresses on the plain register port
package reset_ctrl_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int CNT_W = 14;
	localparam int FILT_W = 4;

	localparam logic [ADDR_W-1:0] REG_RESET_CAUSE = 12'hFF0;
	localparam logic [ADDR_W-1:0] REG_DEBUG_CTRL = 12'hFE0;
	localparam logic [ADDR_W-1:0] REG_WAKE_EN = 12'hFE4;
	localparam logic [ADDR_W-1:0] REG_LOW_SUPPLY_CTRL = 12'hFE8;

	localparam int DBG_RST_BIT = 0;
	localparam int LSD_IRQ_EN_BIT = 0;
	localparam int CAUSE_LSB = 4;
	localparam int LSD_BIT = 0;

	localparam int CLK_PERIOD_NS = 8;
	localparam int OSC_STARTUP_NS = 4000;
	// Least time, so round up
	localparam int STARTUP_CYC =
		(OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LAT_SHORT_CYC = 66;
	localparam int LAT_LONG_CYC = 5000;
	localparam int PIN_QUAL_CYC = 3;

	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;

	typedef struct packed {
		logic watchdog_reset_select_option;
		logic xtal_enable_option;
	} option_bits_type;

	typedef struct packed {
		logic por;
		logic stop_recovery;
		logic watchdog_cause_flag;
		logic external_cause_flag;
	} cause_type;

	localparam cause_type CAUSE_POR = 4'h8;
	localparam cause_type CAUSE_EXT = 4'h1;
	localparam cause_type CAUSE_WDT = 4'h2;
	localparam cause_type CAUSE_SMR_PIN = 4'h4;
	localparam cause_type CAUSE_SMR_WDT = 4'h6;

	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_HOLD = 5'h02,
		ST_PIN_WAIT = 5'h04,
		ST_STOP = 5'h08,
		ST_RECOVER = 5'h10
	} state_type;
endpackage

// file: testbench/board_reset_line.sv
// Purpose: Board parts sharing the open-drain reset line with the block
// Assumes: Line has a pull-up, so a released line reads high
// Notes: Bench commands a low pulse of pull_cyc cycles with pull_go
`timescale 1ns/1ps
`default_nettype none
module board_reset_line (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic pull_go,
	input wire logic [15:0] pull_cyc,
	output logic pin
);
	logic [15:0] cnt_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 16'h0000;
		end else if (pull_go) begin
			cnt_ff <= pull_cyc;
		end else if (cnt_ff != 16'h0000) begin
			cnt_ff <= cnt_ff - 16'h0001;
		end
	end
	// Wired low: any party pulling wins, never a stale level
	assign pin = !((dev_oe && !dev_o) || (cnt_ff != 16'h0000));
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench of the reset and stop recovery block
// Assumes: Long latency shortened to LAT_L for run time
// Notes: Each scenario task drives the block and judges the result
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import reset_ctrl_pkg::*;
	localparam int LAT_L = 80;
	localparam int SHORT = STARTUP_CYC + LAT_SHORT_CYC;
	localparam int LONG = STARTUP_CYC + LAT_L;
	logic ref_clk, rstn, wr_stb, rd_stb, irq_en, pin, pin_o, pin_oe;
	logic [2:0] ev;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	option_bits_type opt;
	logic [7:0] gpio;
	logic dbg_n, sup_low, bo_dis, pull_go, pde;
	logic [15:0] pull_cyc, rvec;
	logic cpu_rst, ctl_rst, reinit, internal_precision_osc, pc_load, pin_en, in_stop;
	logic wirq, lirq;
	int failures, checked, n;

	reset_and_stop_recovery_ctrl #(.LAT_LONG(LAT_L)) DUT (
		.ref_clk(ref_clk), .rstn(rstn), .ce(1'h1), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.options(opt), .watchdog_timeout(ev[0]), .stop_enter(ev[1]),
		.irq_global_en(irq_en), .power_event(ev[2]), .gpio_in(gpio),
		.rst_pin_i(pin), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
		.port_drive_en(pde), .debug_pin_n(dbg_n), .supply_low(sup_low),
		.brownout_disable(bo_dis), .cpu_rst(cpu_rst), .ctl_reg_rst(ctl_rst),
		.stop_reinit(reinit), .ipo_force(internal_precision_osc), .pc_load(pc_load),
		.reset_vector(rvec), .port_input_en(pin_en), .in_stop(in_stop),
		.wdt_irq(wirq), .low_supply_irq(lirq));

	board_reset_line board (.ref_clk(ref_clk), .rstn(rstn), .dev_o(pin_o),
		.dev_oe(pin_oe), .pull_go(pull_go), .pull_cyc(pull_cyc), .pin(pin));

	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chkb(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_stb <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_stb <= 1'h0;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rdc(input logic [11:0] a, input logic [7:0] e,
		input string nm);
		@(posedge ref_clk);
		rd_stb <= 1'h1;
		addr <= a;
		@(posedge ref_clk);
		rd_stb <= 1'h0;
		#1;
		checked++;
		if (rdata !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, rdata);
		end
	endtask

	task automatic pulse(input int w);
		@(posedge ref_clk);
		ev[w] <= 1'h1;
		@(posedge ref_clk);
		ev[w] <= 1'h0;
		#1;
	endtask

	task automatic pull(input int k);
		@(posedge ref_clk);
		pull_cyc <= 16'(k);
		pull_go <= 1'h1;
		@(posedge ref_clk);
		pull_go <= 1'h0;
	endtask

	task automatic wait_exit(output int k);
		k = 0;
		while (pc_load !== 1'h1) begin
			if (k > 3000) begin
				failures++;
				$display("[ERR] exit_wait expected pulse seen none");
				print_verdict();
			end
			cyc(1);
			k++;
		end
	endtask

	task automatic t_por();
		chkb("oe_in_reset", 1'h1, pin_oe);
		wait_exit(n);
		chkb("por_latency", 1'h1, n >= SHORT && n <= SHORT + 8);
		chkb("ipo_force", 1'h1, internal_precision_osc);
		chkb("vector", 1'h1, rvec === RESET_VECTOR_ADDR);
		chkb("port_in_on", 1'h1, pin_en);
		chkb("pin_data_low", 1'h0, pin_o);
		rdc(REG_RESET_CAUSE, 8'h80, "cause_por");
		rdc(REG_RESET_CAUSE, 8'h00, "cause_cleared");
	endtask

	task automatic t_pin();
		pull(2);
		cyc(12);
		chkb("short_pulse", 1'h0, cpu_rst);
		pull(4);
		cyc(12);
		chkb("pin_reset", 1'h1, cpu_rst);
		wait_exit(n);
		rdc(REG_RESET_CAUSE, 8'h10, "cause_ext");
		pull(800);
		cyc(12);
		chkb("pin_oe", 1'h1, pin_oe);
		cyc(680);
		chkb("held_by_pin", 1'h1, cpu_rst);
		chkb("oe_released", 1'h0, pin_oe);
		wait_exit(n);
		chkb("exit_after_pin", 1'h1, n >= 108 && n <= 116);
	endtask

	task automatic t_wdt();
		@(posedge ref_clk);
		opt <= 2'h0;
		pulse(0);
		chkb("wdt_irq", 1'h1, wirq);
		cyc(4);
		chkb("no_reset", 1'h0, cpu_rst);
		@(posedge ref_clk);
		opt <= 2'h2;
		pulse(0);
		cyc(3);
		chkb("wdt_reset", 1'h1, cpu_rst);
		wait_exit(n);
		rdc(REG_RESET_CAUSE, 8'h20, "cause_wdt");
	endtask

	task automatic t_dbg();
		wr(REG_DEBUG_CTRL, 8'h01);
		cyc(3);
		chkb("dbg_reset", 1'h1, cpu_rst);
		wait_exit(n);
		rdc(REG_DEBUG_CTRL, 8'h00, "dbg_req_clear");
		rdc(REG_RESET_CAUSE, 8'h80, "cause_dbg");
		pulse(2);
		cyc(2);
		chkb("pwr_oe", 1'h1, pin_oe);
		wait_exit(n);
	endtask

	task automatic t_smr_wdt();
		logic seen;
		@(posedge ref_clk);
		opt <= 2'h0;
		irq_en <= 1'h1;
		wr(REG_WAKE_EN, 8'h01);
		pulse(1);
		cyc(1);
		chkb("in_stop", 1'h1, in_stop);
		chkb("port_in_off", 1'h0, pin_en);
		pulse(0);
		cyc(2);
		chkb("reinit", 1'h1, reinit);
		chkb("ctl_kept", 1'h0, ctl_rst);
		wait_exit(n);
		chkb("smr_latency", 1'h1, n >= SHORT - 4 && n <= SHORT + 4);
		chkb("smr_ipo", 1'h1, internal_precision_osc);
		seen = 1'h0;
		repeat (4) begin
			seen = seen | (wirq === 1'h1);
			cyc(1);
		end
		chkb("smr_irq", 1'h1, seen);
		rdc(REG_RESET_CAUSE, 8'h60, "cause_smr_wdt");
		rdc(REG_WAKE_EN, 8'h01, "wake_en_kept");
	endtask

	task automatic t_smr_gpio();
		@(posedge ref_clk);
		opt <= 2'h1;
		pulse(1);
		@(posedge ref_clk);
		gpio <= 8'h02;
		cyc(10);
		chkb("gpio_masked", 1'h1, in_stop);
		@(posedge ref_clk);
		gpio <= 8'h03;
		repeat (2) @(posedge ref_clk);
		gpio <= 8'h02;
		cyc(10);
		chkb("gpio_glitch", 1'h1, in_stop);
		@(posedge ref_clk);
		gpio <= 8'h03;
		wait_exit(n);
		chkb("smr_long", 1'h1, n >= LONG && n <= LONG + 12);
		rdc(REG_RESET_CAUSE, 8'h40, "cause_smr_gpio");
	endtask

	task automatic t_stop_rst();
		@(posedge ref_clk);
		opt <= 2'h2;
		pulse(1);
		pull(2);
		cyc(10);
		chkb("stop_glitch", 1'h1, in_stop);
		@(posedge ref_clk);
		dbg_n <= 1'h0;
		cyc(6);
		chkb("dbg_pin_reset", 1'h1, ctl_rst);
		@(posedge ref_clk);
		dbg_n <= 1'h1;
		wait_exit(n);
		rdc(REG_RESET_CAUSE, 8'h80, "cause_dbg_pin");
		pulse(1);
		pull(8);
		cyc(10);
		chkb("stop_pin_reset", 1'h1, ctl_rst);
		wait_exit(n);
		rdc(REG_RESET_CAUSE, 8'h10, "cause_stop_pin");
	endtask

	task automatic t_lsd();
		@(posedge ref_clk);
		sup_low <= 1'h1;
		cyc(3);
		rdc(REG_RESET_CAUSE, 8'h01, "lsd_live");
		rdc(REG_RESET_CAUSE, 8'h01, "lsd_after_read");
		chkb("lsd_irq_off", 1'h0, lirq);
		wr(REG_LOW_SUPPLY_CTRL, 8'h01);
		cyc(2);
		chkb("lsd_irq", 1'h1, lirq);
		@(posedge ref_clk);
		bo_dis <= 1'h1;
		cyc(2);
		chkb("lsd_bo_off", 1'h0, lirq);
		@(posedge ref_clk);
		sup_low <= 1'h0;
		bo_dis <= 1'h0;
		cyc(3);
		rdc(REG_RESET_CAUSE, 8'h00, "lsd_gone");
		rdc(12'h123, 8'h00, "unmapped");
		@(posedge ref_clk);
		pde <= 1'h1;
		cyc(2);
		chkb("port_drive_oe", 1'h1, pin_oe);
		@(posedge ref_clk);
		pde <= 1'h0;
		cyc(6);
		chkb("port_drive_no_rst", 1'h0, cpu_rst);
	endtask

	initial begin
		failures = 0;
		checked = 0;
		rstn = 1'h0;
		wr_stb = 1'h0;
		rd_stb = 1'h0;
		addr = '0;
		wdata = '0;
		ev = 3'h0;
		opt = 2'h2;
		irq_en = 1'h0;
		gpio = 8'h00;
		dbg_n = 1'h1;
		sup_low = 1'h0;
		bo_dis = 1'h0;
		pull_go = 1'h0;
		pde = 1'h0;
		pull_cyc = 16'h0000;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'h1;
		#1;
		t_por();
		t_pin();
		t_wdt();
		t_dbg();
		t_smr_wdt();
		t_smr_gpio();
		t_stop_rst();
		t_lsd();
		print_verdict();
	end
endmodule
`default_nettype wire
